/* File: rtl/kwi_top.sv */
/*
  Keypad wake interrupt: five key pins, request latch with edge or
  edge-and-level sensitivity, Avalon-MM registers, event status/mask.
  Assumes key pins synchronous-capable inputs, external pullups gated by
  pullup_en_o, and a one-cycle vector fetch strobe from the processor.
*/
`timescale 1ns/1ps
module kwi_top #(
  parameter int unsigned PINS = kwi_pkg::KWI_PINS
) (
  input wire logic sys_clk_i, // 40 MHz bus clock
  input wire logic rst_i, // Async reset, active high
  input wire logic [7:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read strobe
  input wire logic avs_write_i, // Write strobe
  input wire logic [31:0] avs_writedata_i, // Write data
  input wire logic [3:0] avs_byteenable_i, // Byte enables
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Stall
  input wire logic [PINS-1:0] key_request_pins_i, // Key pin levels
  input wire logic vector_fetch_i, // Interrupt acknowledge pulse
  input wire logic break_state_i, // Debug break active
  output logic [PINS-1:0] pullup_en_o, // Pullup enable per pin
  output logic [PINS-1:0] force_input_o, // Override direction to input
  output logic key_irq_o, // Request to processor, also wakes it
  output logic evt_irq_o // Event status interrupt
);
  logic [PINS-1:0] sync1_q, sync2_q, pins_prev_q;
  logic [PINS-1:0] pin_request_enables_q, pin_en_d;
  logic trigger_sensitivity_bit_q, sens_d;
  logic request_mask_bit_q, mask_d;
  logic break_clear_enable_q, break_clear_enable_d;
  logic request_pending_flag_q, flag_d;
  logic ack_seen_q, ack_seen_d;
  logic [kwi_pkg::KWI_EVT_W-1:0] evt_stat_q, evt_stat_d, evt_mask_q, evt_mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_phase_q, ack_phase_d;
  logic wr, rd, ack_wr, any_low, all_high_prev, latch_ev, clear_req;
  logic [31:0] wdata;

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  // Two-stage synchroniser; only sync2 is looked at
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      pins_prev_q <= '1;
    end
    else
    begin
      sync1_q <= key_request_pins_i;
      sync2_q <= sync1_q;
      pins_prev_q <= sync2_q | ~pin_request_enables_q;
    end
  end

  // One-cycle waitrequest: each access is answered on its second edge
  always_comb
  begin
    ack_phase_d = (avs_read_i | avs_write_i) & ~ack_phase_q;
  end
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_phase_q;
  assign wr = avs_write_i & ack_phase_q;
  assign rd = avs_read_i & ack_phase_q;
  assign wdata = avs_writedata_i & be_mask(avs_byteenable_i);

  // break blocks acknowledge unless clear enable is set
  assign ack_wr = wr && avs_address_i == kwi_pkg::KWI_ADDR_STAT_CTRL && avs_byteenable_i[0]
    && wdata[kwi_pkg::KWI_BIT_ACK] && (!break_state_i || break_clear_enable_q);
  assign any_low = |(~sync2_q & pin_request_enables_q);
  assign all_high_prev = &pins_prev_q;
  assign latch_ev = any_low & all_high_prev;

  always_comb
  begin
    pin_en_d = pin_request_enables_q;
    sens_d = trigger_sensitivity_bit_q;
    mask_d = request_mask_bit_q;
    break_clear_enable_d = break_clear_enable_q;
    evt_mask_d = evt_mask_q;
    flag_d = request_pending_flag_q;
    ack_seen_d = ack_seen_q;
    clear_req = 1'b0;
    if (wr && avs_byteenable_i[0])
    begin
      case (avs_address_i)
        kwi_pkg::KWI_ADDR_STAT_CTRL:
        begin
          sens_d = wdata[kwi_pkg::KWI_BIT_SENS];
          mask_d = wdata[kwi_pkg::KWI_BIT_MASK];
        end
        kwi_pkg::KWI_ADDR_PIN_EN: pin_en_d = wdata[PINS-1:0];
        kwi_pkg::KWI_ADDR_EVT_MASK: evt_mask_d = wdata[kwi_pkg::KWI_EVT_W-1:0];
        kwi_pkg::KWI_ADDR_BREAK_CTL: break_clear_enable_d = wdata[kwi_pkg::KWI_BIT_BREAK_CLEAR_ENABLE];
        default: ;
      endcase
    end
    if (request_pending_flag_q)
    begin
      if (!trigger_sensitivity_bit_q)
      begin
        if (ack_wr || vector_fetch_i)
        begin
          flag_d = 1'b0;
          clear_req = 1'b1;
        end
      end
      else
      begin
        // acknowledge remembered until pins return high
        if (ack_wr || vector_fetch_i)
          ack_seen_d = 1'b1;
        if ((ack_seen_q || ack_wr || vector_fetch_i) && !any_low)
        begin
          flag_d = 1'b0;
          ack_seen_d = 1'b0;
          clear_req = 1'b1;
        end
      end
    end
    // Set wins over a clear in the same cycle
    if (latch_ev)
    begin
      flag_d = 1'b1;
      ack_seen_d = 1'b0;
    end
  end

  // Event status: set wins over write-one-to-clear
  always_comb
  begin
    evt_stat_d = evt_stat_q;
    if (wr && avs_address_i == kwi_pkg::KWI_ADDR_EVT_STAT && avs_byteenable_i[0])
      evt_stat_d = evt_stat_q & ~wdata[kwi_pkg::KWI_EVT_W-1:0];
    if (latch_ev)
      evt_stat_d[kwi_pkg::KWI_EVT_LATCH] = 1'b1;
    if (clear_req)
      evt_stat_d[kwi_pkg::KWI_EVT_CLEAR] = 1'b1;
  end

  always_comb
  begin
    rdata_d = rdata_q;
    if (rd)
    begin
      case (avs_address_i)
        kwi_pkg::KWI_ADDR_STAT_CTRL:
        begin
          rdata_d = '0; // upper bits and acknowledge read zero
          rdata_d[kwi_pkg::KWI_BIT_FLAG] = request_pending_flag_q;
          rdata_d[kwi_pkg::KWI_BIT_MASK] = request_mask_bit_q;
          rdata_d[kwi_pkg::KWI_BIT_SENS] = trigger_sensitivity_bit_q;
        end
        kwi_pkg::KWI_ADDR_PIN_EN: rdata_d = 32'(pin_request_enables_q);
        kwi_pkg::KWI_ADDR_EVT_STAT: rdata_d = 32'(evt_stat_q);
        kwi_pkg::KWI_ADDR_EVT_MASK: rdata_d = 32'(evt_mask_q);
        kwi_pkg::KWI_ADDR_BREAK_CTL: rdata_d = 32'(break_clear_enable_q);
        default: rdata_d = kwi_pkg::KWI_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_request_enables_q <= '0;
      trigger_sensitivity_bit_q <= 1'b0;
      request_mask_bit_q <= 1'b0;
      break_clear_enable_q <= 1'b0;
      request_pending_flag_q <= 1'b0;
      ack_seen_q <= 1'b0;
      evt_stat_q <= '0;
      evt_mask_q <= '0;
      rdata_q <= '0;
      ack_phase_q <= 1'b0;
    end
    else
    begin
      pin_request_enables_q <= pin_en_d;
      trigger_sensitivity_bit_q <= sens_d;
      request_mask_bit_q <= mask_d;
      break_clear_enable_q <= break_clear_enable_d;
      request_pending_flag_q <= flag_d;
      ack_seen_q <= ack_seen_d;
      evt_stat_q <= evt_stat_d;
      evt_mask_q <= evt_mask_d;
      rdata_q <= rdata_d;
      ack_phase_q <= ack_phase_d;
    end
  end

  // Read data registered at the accepting edge is visible one cycle late;
  // combinational mux gives data at the waitrequest-low edge itself
  assign avs_readdata_o = rdata_d;
  assign pullup_en_o = pin_request_enables_q;
  assign force_input_o = pin_request_enables_q;
  assign key_irq_o = request_pending_flag_q & ~request_mask_bit_q;
  assign evt_irq_o = |(evt_stat_q & evt_mask_q);

  a_irq_gating: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    key_irq_o == (request_pending_flag_q && !request_mask_bit_q))
    else $error("key irq not flag gated by mask");
  a_latch_sets: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    latch_ev |=> request_pending_flag_q)
    else $error("request not latched");
  a_edge_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    request_pending_flag_q && !trigger_sensitivity_bit_q && vector_fetch_i && !latch_ev
    |=> !request_pending_flag_q)
    else $error("edge mode fetch did not clear");
  a_level_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    request_pending_flag_q && trigger_sensitivity_bit_q && any_low
    |=> request_pending_flag_q)
    else $error("level request cleared while pin low");
  a_break_protect: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    break_state_i && !break_clear_enable_q && !vector_fetch_i && request_pending_flag_q
    |=> request_pending_flag_q)
    else $error("flag cleared in protected break");
  a_break_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ack_wr && break_state_i && !trigger_sensitivity_bit_q && request_pending_flag_q
    && !latch_ev |=> !request_pending_flag_q)
    else $error("break clear did not clear flag");
  a_upper_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd && avs_address_i == kwi_pkg::KWI_ADDR_STAT_CTRL
    |-> avs_readdata_o[31:4] == '0 && !avs_readdata_o[kwi_pkg::KWI_BIT_ACK])
    else $error("status upper bits not zero");
  a_no_latch_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !request_pending_flag_q && $stable(pin_request_enables_q) && ~|pin_request_enables_q
    |=> !request_pending_flag_q)
    else $error("latched with all pins disabled");
  a_force_input: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    force_input_o == pin_request_enables_q && pullup_en_o == pin_request_enables_q)
    else $error("enabled pin not forced input");
  a_wait_one: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest longer than one cycle");

  c_edge_req: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    latch_ev && !trigger_sensitivity_bit_q);
  c_level_clear: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    clear_req && trigger_sensitivity_bit_q);
  c_break_ack: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    break_state_i && wr && avs_address_i == kwi_pkg::KWI_ADDR_STAT_CTRL);
  c_evt_irq: cover property (@(posedge sys_clk_i) disable iff (rst_i) evt_irq_o);
  c_break_keep: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    break_state_i && !break_clear_enable_q && request_pending_flag_q);

  // Level mode: a remembered acknowledge must finish the clear once pins are high
  a_level_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    request_pending_flag_q && trigger_sensitivity_bit_q && ack_seen_q && !any_low
    && !latch_ev |=> !request_pending_flag_q)
    else $error("level request not cleared after pins high");

  // Acknowledge while a pin is still low must not be lost
  a_ack_remember: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    request_pending_flag_q && trigger_sensitivity_bit_q && ack_wr && any_low
    && !latch_ev |=> ack_seen_q)
    else $error("level acknowledge forgotten");

  // Latched event bit is sticky until software clears it
  a_evt_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    evt_stat_q[kwi_pkg::KWI_EVT_LATCH]
    && !(wr && avs_address_i == kwi_pkg::KWI_ADDR_EVT_STAT)
    |=> evt_stat_q[kwi_pkg::KWI_EVT_LATCH])
    else $error("event status bit lost");

  a_evt_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    latch_ev |=> evt_stat_q[kwi_pkg::KWI_EVT_LATCH])
    else $error("latch event not recorded");

  a_pin_en_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr && avs_byteenable_i[0] && avs_address_i == kwi_pkg::KWI_ADDR_PIN_EN
    |=> pin_request_enables_q == $past(wdata[PINS-1:0]))
    else $error("pin enable write lost");

  a_mask_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr && avs_byteenable_i[0] && avs_address_i == kwi_pkg::KWI_ADDR_STAT_CTRL
    |=> request_mask_bit_q == $past(wdata[kwi_pkg::KWI_BIT_MASK]))
    else $error("mask write lost");

  // Flag, mask, sensitivity and pin enable registers are held clear for as long as reset stands
  a_reset_clear: assert property (@(posedge sys_clk_i)
    rst_i |-> !request_pending_flag_q && !request_mask_bit_q
    && !trigger_sensitivity_bit_q && pin_request_enables_q == '0)
    else $error("state not cleared in reset");

  // Without a latch event the flag can never rise by itself
  a_no_spont_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !request_pending_flag_q && !latch_ev |=> !request_pending_flag_q)
    else $error("flag set without key event");

  a_flag_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd && avs_address_i == kwi_pkg::KWI_ADDR_STAT_CTRL
    |-> avs_readdata_o[kwi_pkg::KWI_BIT_FLAG] == request_pending_flag_q)
    else $error("pending flag misread");

  // The first cycle of every access must stall
  a_wait_first: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (avs_read_i || avs_write_i) && !ack_phase_q |-> avs_waitrequest_o)
    else $error("access accepted without wait cycle");
endmodule : kwi_top

/* File: shared/kwi_pkg.sv */
/*
  Constants for the keypad wake interrupt block: register map, field
  positions, reset values and the status/mask interrupt layout.
  Assumes a 32-bit Avalon-MM slave with word addressing by byte offset.
*/
// Behaviour
// - Enabling a pin turns on its pullup; a spurious request may latch then.
// - Detection continues in wait mode; unmasked request wakes the processor.
// - Detection continues in stop mode; unmasked request wakes the processor.
// - In break with clear enable set, acknowledge clears flag; stays cleared.
// - In break with clear enable zero, acknowledge writes are ignored.
// - Upper four status/control bits read zero; writes ignored.
// - Pending flag reads one while request latched; reset clears it.
// - Writing one to acknowledge clears request; bit reads zero.
// - Mask one blocks the interrupt; zero forwards it; reset clears mask.
// - Sensitivity one: edges and low levels; zero: falling edges only.
// - Each of five enable bits admits its pin; reset clears all.
// - Latch when enabled pins go low after all were high.
// - Edge-only mode: vector fetch or acknowledge clears request immediately.
// - Level mode: clear needs acknowledge and all pins high, any order.
// - An enabled pin is forced to input, overriding its direction bit.
package kwi_pkg;
  localparam int unsigned KWI_PINS = 5;
  localparam logic [7:0] KWI_ADDR_STAT_CTRL = 8'h00;
  localparam logic [7:0] KWI_ADDR_PIN_EN = 8'h04;
  localparam logic [7:0] KWI_ADDR_EVT_STAT = 8'h08;
  localparam logic [7:0] KWI_ADDR_EVT_MASK = 8'h0C;
  localparam logic [7:0] KWI_ADDR_BREAK_CTL = 8'h10;
  localparam int unsigned KWI_BIT_SENS = 0;
  localparam int unsigned KWI_BIT_MASK = 1;
  localparam int unsigned KWI_BIT_ACK = 2;
  localparam int unsigned KWI_BIT_FLAG = 3;
  localparam int unsigned KWI_BIT_BREAK_CLEAR_ENABLE = 0;
  localparam int unsigned KWI_EVT_LATCH = 0;
  localparam int unsigned KWI_EVT_CLEAR = 1;
  localparam int unsigned KWI_EVT_W = 2;
  localparam logic [7:0] KWI_RST_CTRL = 8'h00;
  localparam logic [31:0] KWI_UNMAPPED = 32'h0000_0000;
endpackage : kwi_pkg

/* File: verification/kwi_keypad.sv */
/*
  Keypad switch model: a pressed key pulls its pin low.
  Assumes the block switches the pullups; a pullup needs one clock to lift its pin.
*/
`timescale 1ns/1ps
module kwi_keypad (
  input wire logic sys_clk_i, // Bus clock
  input wire logic [4:0] pullup_en_i, // Pullups switched on by the block
  input wire logic [4:0] press_i, // Keys held down
  input wire logic [4:0] drive_hi_i, // Port outputs driving ones before enable
  output logic [4:0] pins_o // Pin levels
);
  logic [4:0] lifted_q = 5'h00;
  logic [4:0] float_q = 5'h0A;
  always_ff @(posedge sys_clk_i)
  begin
    lifted_q <= pullup_en_i;
    float_q <= ~float_q;
  end
  // Undriven pins wander, so a stale level never passes for a pullup
  assign pins_o = ~press_i & ((pullup_en_i & lifted_q) | (~pullup_en_i & float_q)
    | drive_hi_i);
endmodule : kwi_keypad

/* File: verification/kwi_top_bench.sv */
/*
  Self-checking bench for the keypad wake interrupt block.
  Assumes kwi_top, the kwi_keypad switch model and a one-wait-cycle slave.
*/
`timescale 1ns/1ps
module kwi_top_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, got;
  logic wreq, vf = 1'b0, brk = 1'b0, kirq, eirq;
  logic [4:0] pins, pu, fin, press = 5'h00, drv = 5'h1F;
  int error_cnt = 0;
  int check_count = 0;
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  kwi_top dut_u (.sys_clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .key_request_pins_i(pins),
    .vector_fetch_i(vf), .break_state_i(brk), .pullup_en_o(pu), .force_input_o(fin),
    .key_irq_o(kirq), .evt_irq_o(eirq));
  kwi_keypad pad_u (.sys_clk_i(clk), .pullup_en_i(pu), .press_i(press), .drive_hi_i(drv),
    .pins_o(pins));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] val);
    check_count++;
    if (val !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, val);
    end
  endtask : chk
  task automatic access(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdat <= d;
    // Waitrequest and read data are looked at on the rising edge that takes them
    do
    begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50)
      chk("waitrequest", 32'h0, 32'h1);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : access
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    access(a, 1'b0, 32'h0);
    chk($sformatf("reg %h", a), exp, got);
  endtask : rd_chk
  task automatic settle(input logic [4:0] keys);
    press <= keys;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial
  begin
    // Whole sequence needs well under a thousand cycles
    #2000000;
    error_cnt++;
    complete_run();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h0);
    access(8'h00, 1'b1, 32'h02);
    access(8'h04, 1'b1, 32'h1F);
    settle(5'h00);
    chk("pullups", 32'h1F, {27'h0, pu});
    chk("force", 32'h1F, {27'h0, fin});
    drv <= 5'h00;
    access(8'h00, 1'b1, 32'h06);
    access(8'h00, 1'b1, 32'hF0);
    rd_chk(8'h00, 32'h0);
    settle(5'h01);
    chk("key irq", 32'h1, {31'h0, kirq});
    rd_chk(8'h00, 32'h08);
    access(8'h00, 1'b1, 32'h04);
    rd_chk(8'h00, 32'h0);
    settle(5'h03);
    rd_chk(8'h00, 32'h0);
    settle(5'h00);
    access(8'h00, 1'b1, 32'h02);
    settle(5'h04);
    chk("masked irq", 32'h0, {31'h0, kirq});
    rd_chk(8'h00, 32'h0A);
    access(8'h00, 1'b1, 32'h00);
    @(negedge clk);
    chk("unmasked irq", 32'h1, {31'h0, kirq});
    access(8'h00, 1'b1, 32'h04);
    settle(5'h00);
    access(8'h00, 1'b1, 32'h01);
    settle(5'h08);
    rd_chk(8'h00, 32'h09);
    access(8'h00, 1'b1, 32'h05);
    rd_chk(8'h00, 32'h09);
    settle(5'h00);
    rd_chk(8'h00, 32'h01);
    access(8'h00, 1'b1, 32'h00);
    brk <= 1'b1;
    settle(5'h10);
    access(8'h00, 1'b1, 32'h04);
    rd_chk(8'h00, 32'h08);
    access(8'h10, 1'b1, 32'h01);
    access(8'h00, 1'b1, 32'h04);
    brk <= 1'b0;
    settle(5'h10);
    rd_chk(8'h00, 32'h0);
    settle(5'h00);
    settle(5'h01);
    @(posedge clk);
    vf <= 1'b1;
    @(posedge clk);
    vf <= 1'b0;
    rd_chk(8'h00, 32'h0);
    settle(5'h00);
    rd_chk(8'h08, 32'h03);
    access(8'h0C, 1'b1, 32'h03);
    @(negedge clk);
    chk("event irq", 32'h1, {31'h0, eirq});
    access(8'h08, 1'b1, 32'h03);
    rd_chk(8'h08, 32'h0);
    chk("event irq clear", 32'h0, {31'h0, eirq});
    rd_chk(8'h20, 32'h0);
    complete_run();
  end
endmodule : kwi_top_bench
